// >>> seq_pkg.sv
// Constants, register map and types of the masked event step sequencer.
// Assumes a 20 MHz core clock and a 32-bit AXI4-Lite register bus.
package seq_pkg;
    localparam int STEPS = 16;
    localparam int OUT_W = 16;
    localparam int IDX_W = 4;
    localparam int TGT_W = 14;
    localparam int MIDX_W = 5;
    localparam int PRE_W = 18;
    localparam int ADDR_W = 12;
    localparam int CTRL_W = 5;
    // Time unit of the time base, and the core clock period
    localparam int UNIT_NS = 10_000_000;
    localparam int CLK_NS = 50;
    localparam int UNIT_CYCLES = UNIT_NS / CLK_NS;
    localparam logic [TGT_W-1:0] TARGET_MAX = 14'h270F;
    localparam logic [IDX_W-1:0] LAST_STEP = 4'hF;
    localparam logic [4:0] PRESET_MIN = 5'h01;
    localparam logic [4:0] PRESET_MAX = 5'h10;
    localparam logic [4:0] PRESET_RST = 5'h01;
    // Register byte addresses
    localparam logic [ADDR_W-1:0] OFF_CTRL = 12'h000;
    localparam logic [ADDR_W-1:0] OFF_EVENT = 12'h004;
    localparam logic [ADDR_W-1:0] OFF_TBASE = 12'h008;
    localparam logic [ADDR_W-1:0] OFF_MBASE = 12'h00C;
    localparam logic [ADDR_W-1:0] OFF_COUNT = 12'h010;
    localparam logic [ADDR_W-1:0] OFF_TIMER = 12'h014;
    localparam logic [ADDR_W-1:0] OFF_PRESET = 12'h018;
    localparam logic [ADDR_W-1:0] OFF_CUR = 12'h01C;
    localparam logic [ADDR_W-1:0] OFF_STAT = 12'h020;
    localparam logic [ADDR_W-1:0] OFF_OUTW = 12'h024;
    localparam logic [ADDR_W-1:0] OFF_PAT = 12'h100;
    localparam logic [ADDR_W-1:0] OFF_CFG = 12'h140;
    localparam logic [ADDR_W-1:0] OFF_MASK = 12'h200;
    localparam logic [ADDR_W-1:0] SPAN16 = 12'h040;
    localparam logic [ADDR_W-1:0] SPAN32 = 12'h080;
    // Control register bits
    localparam int CB_RUN = 0;
    localparam int CB_START = 1;
    localparam int CB_RESET = 2;
    localparam int CB_JOG = 3;
    localparam int CB_WORD = 4;
    // Step configuration word: count target low, event flag above
    localparam int CFG_EV = 16;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_RUN = 2'b01,
        ST_DONE = 2'b11
    } seq_state_e;

    typedef struct packed {
        logic [15:0] count;
        logic [15:0] timer;
        logic [15:0] preset;
        logic [15:0] current;
    } status_s;
endpackage

// >>> masked_event_step_sequencer.sv
// Sixteen-step masked output sequencer with an AXI4-Lite register file.
// Assumes synchronous inputs, one 20 MHz clock and a single bus master.
`timescale 1ns/1ps
`default_nettype none

module masked_event_step_sequencer
    import seq_pkg::*;
#(
    parameter int UNIT_CYC = UNIT_CYCLES // Core cycles per 0.01 s
) (
    input wire logic i_core_clk, // Core clock
    input wire logic i_rst_n, // Async reset, active low
    input wire logic i_ce, // Clock enable, freezes all state
    input wire logic [ADDR_W-1:0] i_s_axi_awaddr, // Write address
    input wire logic i_s_axi_awvalid, // Write address valid
    output logic o_s_axi_awready, // Write address ready
    input wire logic [31:0] i_s_axi_wdata, // Write data
    input wire logic [3:0] i_s_axi_wstrb, // Write byte strobes
    input wire logic i_s_axi_wvalid, // Write data valid
    output logic o_s_axi_wready, // Write data ready
    output logic [1:0] o_s_axi_bresp, // Write response
    output logic o_s_axi_bvalid, // Write response valid
    input wire logic i_s_axi_bready, // Write response ready
    input wire logic [ADDR_W-1:0] i_s_axi_araddr, // Read address
    input wire logic i_s_axi_arvalid, // Read address valid
    output logic o_s_axi_arready, // Read address ready
    output logic [31:0] o_s_axi_rdata, // Read data
    output logic [1:0] o_s_axi_rresp, // Read response
    output logic o_s_axi_rvalid, // Read data valid
    input wire logic i_s_axi_rready, // Read data ready
    output logic [OUT_W-1:0] o_discrete, // Discrete output points
    output logic [OUT_W-1:0] o_word_out, // Output word
    output logic o_complete, // Completion flag
    output status_s o_status // Four status counters
);
    logic [CTRL_W-1:0] ctrl;
    logic [OUT_W-1:0] event_reg;
    logic [TGT_W-1:0] timebase;
    logic [MIDX_W-1:0] mask_base;
    logic [4:0] preset;
    logic [OUT_W-1:0] pattern [STEPS];
    logic [CFG_EV:0] cfg [STEPS];
    logic [OUT_W-1:0] mask_mem [2*STEPS];

    logic [IDX_W-1:0] cur;
    logic [TGT_W-1:0] cnt;
    logic [TGT_W-1:0] tmr;
    logic [PRE_W-1:0] pre;
    logic complete;
    logic run_q;
    logic jog_q;
    seq_state_e state;

    logic aw_held;
    logic w_held;
    logic [ADDR_W-1:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;

    function automatic logic is_blk(input logic [ADDR_W-1:0] a,
                                    input logic [ADDR_W-1:0] base,
                                    input logic [ADDR_W-1:0] span);
        return (a >= base) && (a < base + span) && (a[1:0] == 2'b00);
    endfunction

    // Register decode shared by the read path and write merging
    function automatic logic [32:0] reg_val(input logic [ADDR_W-1:0] a);
        logic [32:0] r;
        r = {1'b1, 32'h0000_0000};
        if (is_blk(a, OFF_PAT, SPAN16))
            r[15:0] = pattern[a[5:2]];
        else if (is_blk(a, OFF_CFG, SPAN16))
            r[CFG_EV:0] = cfg[a[5:2]];
        else if (is_blk(a, OFF_MASK, SPAN32))
            r[15:0] = mask_mem[a[6:2]];
        else if (a == OFF_CTRL)
            r[CTRL_W-1:0] = ctrl;
        else if (a == OFF_EVENT)
            r[15:0] = event_reg;
        else if (a == OFF_TBASE)
            r[TGT_W-1:0] = timebase;
        else if (a == OFF_MBASE)
            r[MIDX_W-1:0] = mask_base;
        else if (a == OFF_COUNT)
            r[15:0] = o_status.count;
        else if (a == OFF_TIMER)
            r[15:0] = o_status.timer;
        else if (a == OFF_PRESET)
            r[15:0] = o_status.preset;
        else if (a == OFF_CUR)
            r[15:0] = o_status.current;
        else if (a == OFF_STAT)
            r[2:0] = {state, complete};
        else if (a == OFF_OUTW)
            r[15:0] = o_word_out;
        else
            r[32] = 1'b0;
        return r;
    endfunction

    function automatic logic [31:0] wmerge(input logic [31:0] old,
                                           input logic [31:0] dat,
                                           input logic [3:0] strb);
        logic [31:0] m;
        m = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b])
                m[8*b +: 8] = dat[8*b +: 8];
        end
        return m;
    endfunction

    // Bus slave
    logic wr_fire;
    logic [32:0] wr_old;
    logic [31:0] wr_word;
    logic [32:0] rd_hit;
    logic [IDX_W-1:0] wi16;
    logic [MIDX_W-1:0] wi32;
    logic preset_ok;
    assign wr_fire = aw_held && w_held && !o_s_axi_bvalid;
    // Comb process so register updates retrigger the shared decode
    always_comb begin
        wr_old = reg_val(aw_addr);
        rd_hit = reg_val(i_s_axi_araddr);
    end
    assign wr_word = wmerge(wr_old[31:0], w_data, w_strb);
    assign wi16 = aw_addr[5:2];
    assign wi32 = aw_addr[6:2];
    assign preset_ok = (wr_word[4:0] >= PRESET_MIN) &&
                       (wr_word[4:0] <= PRESET_MAX) && (wr_word[15:5] == '0);
    assign o_s_axi_awready = !aw_held && !o_s_axi_bvalid;
    assign o_s_axi_wready = !w_held && !o_s_axi_bvalid;
    assign o_s_axi_arready = !o_s_axi_rvalid;

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= '0;
            w_data <= '0;
            w_strb <= '0;
            o_s_axi_bvalid <= 1'b0;
            o_s_axi_bresp <= RESP_OKAY;
            o_s_axi_rvalid <= 1'b0;
            o_s_axi_rresp <= RESP_OKAY;
            o_s_axi_rdata <= '0;
        end else if (i_ce) begin
            if (i_s_axi_awvalid && o_s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= i_s_axi_awaddr;
            end
            if (i_s_axi_wvalid && o_s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= i_s_axi_wdata;
                w_strb <= i_s_axi_wstrb;
            end
            if (wr_fire) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                o_s_axi_bvalid <= 1'b1;
                o_s_axi_bresp <= wr_old[32] ? RESP_OKAY : RESP_SLVERR;
            end else if (i_s_axi_bready)
                o_s_axi_bvalid <= 1'b0;
            if (i_s_axi_arvalid && o_s_axi_arready) begin
                o_s_axi_rvalid <= 1'b1;
                o_s_axi_rdata <= rd_hit[31:0];
                o_s_axi_rresp <= rd_hit[32] ? RESP_OKAY : RESP_SLVERR;
            end else if (i_s_axi_rready)
                o_s_axi_rvalid <= 1'b0;
        end
    end

    // Register file; arrays reset empty so unused steps are blank
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ctrl <= '0;
            event_reg <= '0;
            timebase <= '0;
            mask_base <= '0;
            preset <= PRESET_RST;
            for (int i = 0; i < STEPS; i++) begin
                pattern[i] <= '0;
                cfg[i] <= '0;
            end
            for (int i = 0; i < 2*STEPS; i++)
                mask_mem[i] <= '0;
        end else if (i_ce && wr_fire) begin
            if (aw_addr == OFF_CTRL)
                ctrl <= wr_word[CTRL_W-1:0];
            if (aw_addr == OFF_EVENT)
                event_reg <= wr_word[15:0];
            if (aw_addr == OFF_TBASE)
                timebase <= wr_word[TGT_W-1:0];
            if (aw_addr == OFF_MBASE)
                mask_base <= wr_word[MIDX_W-1:0];
            if (aw_addr == OFF_PRESET && preset_ok)
                preset <= wr_word[4:0];
            if (is_blk(aw_addr, OFF_PAT, SPAN16))
                pattern[wi16] <= wr_word[15:0];
            if (is_blk(aw_addr, OFF_CFG, SPAN16))
                cfg[wi16] <= {wr_word[CFG_EV], 2'b00,
                    (wr_word[TGT_W-1:0] > TARGET_MAX) ? TARGET_MAX :
                    wr_word[TGT_W-1:0]};
            if (is_blk(aw_addr, OFF_MASK, SPAN32))
                mask_mem[wi32] <= wr_word[15:0];
        end
    end

    // Step sequencing
    logic run_mode;
    logic seq_rst;
    logic start;
    logic word_mode;
    logic [TGT_W-1:0] tgt;
    logic ev_used;
    logic unused;
    logic cnt_en;
    logic unit_tick;
    logic count_tick;
    logic [TGT_W-1:0] next_cnt;
    logic time_done;
    logic jog_rise;
    logic load;
    logic advance;
    logic [MIDX_W-1:0] mask_idx;
    logic [OUT_W-1:0] masked;
    assign run_mode = ctrl[CB_RUN];
    assign start = ctrl[CB_START];
    assign word_mode = ctrl[CB_WORD];
    assign tgt = cfg[cur][TGT_W-1:0];
    assign ev_used = cfg[cur][CFG_EV];
    // load on run entry or reset
    assign seq_rst = run_mode && ctrl[CB_RESET];
    assign load = (run_mode && !run_q) || seq_rst;
    assign unused = (timebase == '0) || ((tgt == '0) && !ev_used);
    // timer gated by start and event
    assign cnt_en = start && (!ev_used || event_reg[cur]);
    // one count per time base units
    assign unit_tick = cnt_en && (pre == PRE_W'(UNIT_CYC - 1));
    assign count_tick = unit_tick && (tmr == timebase - 14'h0001);
    assign next_cnt = cnt + 14'h0001;
    assign time_done = cnt_en &&
                       ((tgt == '0) || (count_tick && next_cnt >= tgt));
    assign jog_rise = ctrl[CB_JOG] && !jog_q;
    assign advance = (state == ST_RUN) && (jog_rise || unused || time_done);
    assign mask_idx = mask_base + MIDX_W'(cur);
    assign masked = pattern[cur] & mask_mem[mask_idx];

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            run_q <= 1'b0;
            jog_q <= 1'b0;
        end else if (i_ce) begin
            run_q <= run_mode;
            jog_q <= ctrl[CB_JOG];
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state <= ST_IDLE;
            cur <= '0;
            cnt <= '0;
            tmr <= '0;
            pre <= '0;
            complete <= 1'b0;
        end else if (i_ce) begin
            if (!run_mode)
                state <= ST_IDLE;
            else if (load) begin
                state <= ST_RUN;
                cur <= IDX_W'(preset - PRESET_MIN);
                cnt <= '0;
                tmr <= '0;
                pre <= '0;
                complete <= 1'b0;
            end else if (advance) begin
                cnt <= '0;
                tmr <= '0;
                pre <= '0;
                if (cur == LAST_STEP) begin
                    state <= ST_DONE;
                    complete <= 1'b1;
                end else
                    cur <= cur + 4'h1;
            end else if (state == ST_RUN && cnt_en) begin
                pre <= unit_tick ? '0 : pre + 18'h00001;
                if (count_tick) begin
                    tmr <= '0;
                    cnt <= next_cnt;
                end else if (unit_tick)
                    tmr <= tmr + 14'h0001;
            end
        end
    end

    // variant outputs, live in run mode
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_discrete <= '0;
            o_word_out <= '0;
        end else if (i_ce) begin
            o_discrete <= (run_mode && !word_mode) ? masked : '0;
            o_word_out <= (run_mode && word_mode) ? masked : '0;
        end
    end

    assign o_status.count = {2'b00, cnt};
    assign o_status.timer = {2'b00, tmr};
    assign o_status.preset = {11'h000, preset};
    assign o_status.current = {11'h000, 5'(cur) + 5'h01};
    assign o_complete = complete;

    AST_MASK_OUT: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        (i_ce && run_mode && !word_mode) |=> o_discrete == $past(masked))
        else $error("discrete outputs differ from masked pattern");
    AST_PRESET_LOAD: assert property (@(posedge i_core_clk)
        disable iff (!i_rst_n) (i_ce && seq_rst)
        |=> o_status.current == {11'h000, $past(preset)} && cnt == '0)
        else $error("reset did not load preset step");
    AST_JOG_STEP: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        (i_ce && run_mode && state == ST_RUN && jog_rise && !load &&
        cur != LAST_STEP)
        |=> cur == 4'($past(cur) + 4'h1))
        else $error("jog edge did not advance one step");
    AST_DONE_SET: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        (i_ce && run_mode && advance && !load && cur == LAST_STEP)
        |=> complete && state == ST_DONE)
        else $error("completion flag missing after last step");
    AST_DONE_CLR: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        (i_ce && seq_rst) |=> !complete[*2])
        else $error("completion flag survived reset");
    AST_START_GATE: assert property (@(posedge i_core_clk)
        disable iff (!i_rst_n) (i_ce && !start && !load && !advance)
        |=> $stable(cnt) && $stable(tmr) && $stable(pre))
        else $error("timer ran without start");
    AST_CNT_CLEAR: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        (i_ce && run_mode && advance && !load) |=> cnt == '0 && tmr == '0)
        else $error("count not cleared on new step");
    AST_IDLE_OUT: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        (i_ce && !run_mode) |=> o_discrete == '0 && o_word_out == '0)
        else $error("outputs active outside run mode");
    AST_HALT: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        (i_ce && state == ST_DONE && run_mode && !load) |=> $stable(cur))
        else $error("step moved after completion");
endmodule

`default_nettype wire

// >>> seq_ladder_model.sv
// Ladder-program side of the sequencer: AXI4-Lite master tasks.
// Assumes one clock and a bench top that owns the closing report.
`timescale 1ns/1ps
`default_nettype none
module seq_ladder_model
    import seq_pkg::*;
(
    input wire logic i_core_clk, // Core clock
    output logic [ADDR_W-1:0] o_awaddr, // Write address
    output logic o_awvalid, // Write address valid
    input wire logic i_awready, // Write address ready
    output logic [31:0] o_wdata, // Write data
    output logic o_wvalid, // Write data valid
    input wire logic i_wready, // Write data ready
    input wire logic i_bvalid, // Write response valid
    output logic o_bready, // Write response ready
    output logic [ADDR_W-1:0] o_araddr, // Read address
    output logic o_arvalid, // Read address valid
    input wire logic i_arready, // Read address ready
    input wire logic i_rvalid, // Read data valid
    input wire logic [31:0] i_rdata, // Read data
    input wire logic [1:0] i_rresp, // Read response
    output logic o_rready // Read data ready
);
    initial begin
        {o_awaddr, o_awvalid, o_wdata, o_wvalid, o_bready} = '0;
        {o_araddr, o_arvalid, o_rready} = '0;
    end

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
        int n;
        @(posedge i_core_clk);
        o_awaddr <= a;
        o_wdata <= d;
        o_awvalid <= 1'b1;
        o_wvalid <= 1'b1;
        o_bready <= 1'b1;
        for (n = 0; n < 100; n++) begin
            @(posedge i_core_clk);
            if (o_awvalid && i_awready) o_awvalid <= 1'b0;
            if (o_wvalid && i_wready) o_wvalid <= 1'b0;
            if (i_bvalid) break;
        end
        o_bready <= 1'b0;
        if (n == 100) masked_event_step_sequencer_tb_top.hang();
    endtask

    task automatic rd(input logic [ADDR_W-1:0] a, output logic [31:0] d,
                      output logic [1:0] r);
        int n;
        @(posedge i_core_clk);
        o_araddr <= a;
        o_arvalid <= 1'b1;
        o_rready <= 1'b1;
        for (n = 0; n < 100; n++) begin
            @(posedge i_core_clk);
            if (o_arvalid && i_arready) o_arvalid <= 1'b0;
            if (i_rvalid) break;
        end
        d = i_rdata;
        r = i_rresp;
        o_rready <= 1'b0;
        if (n == 100) masked_event_step_sequencer_tb_top.hang();
    endtask
endmodule
`default_nettype wire

// >>> masked_event_step_sequencer_tb_top.sv
// Bench for the masked step sequencer, driven over AXI4-Lite.
// Assumes the ladder model file and a shortened count unit.
`timescale 1ns/1ps
`default_nettype none
module masked_event_step_sequencer_tb_top
    import seq_pkg::*;
;
    logic i_core_clk;
    logic i_rst_n;
    logic ce;
    logic [ADDR_W-1:0] awaddr, araddr;
    logic awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready;
    logic [31:0] wdata, rdata, rv;
    logic [1:0] bresp, rresp, rr;
    logic [OUT_W-1:0] o_discrete, o_word_out;
    logic o_complete;
    status_s o_status;
    int bad_count;
    int checks;
    int n;

    masked_event_step_sequencer #(.UNIT_CYC(4)) dut_u (
        .i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_ce(ce),
        .i_s_axi_awaddr(awaddr), .i_s_axi_awvalid(awvalid),
        .o_s_axi_awready(awready), .i_s_axi_wdata(wdata),
        .i_s_axi_wstrb(4'hF), .i_s_axi_wvalid(wvalid),
        .o_s_axi_wready(wready), .o_s_axi_bresp(bresp),
        .o_s_axi_bvalid(bvalid), .i_s_axi_bready(bready),
        .i_s_axi_araddr(araddr), .i_s_axi_arvalid(arvalid),
        .o_s_axi_arready(arready), .o_s_axi_rdata(rdata),
        .o_s_axi_rresp(rresp), .o_s_axi_rvalid(rvalid),
        .i_s_axi_rready(rready), .o_discrete(o_discrete),
        .o_word_out(o_word_out), .o_complete(o_complete),
        .o_status(o_status));

    seq_ladder_model p_u (
        .i_core_clk(i_core_clk), .o_awaddr(awaddr), .o_awvalid(awvalid),
        .i_awready(awready), .o_wdata(wdata), .o_wvalid(wvalid),
        .i_wready(wready), .i_bvalid(bvalid), .o_bready(bready),
        .o_araddr(araddr), .o_arvalid(arvalid), .i_arready(arready),
        .i_rvalid(rvalid), .i_rdata(rdata), .i_rresp(rresp),
        .o_rready(rready));

    function automatic logic [15:0] pat(input int k);
        return 16'hA5C3 ^ (16'(k) * 16'h0111);
    endfunction

    function automatic logic [15:0] msk(input int i);
        return 16'hFF0F ^ (16'(i) * 16'h0901);
    endfunction

    task automatic check(input string nm, input logic [31:0] seen,
                         input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic conclude();
        if (bad_count == 0 && checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    task automatic hang();
        bad_count++;
        conclude();
    endtask

    task automatic cyc(input int c);
        repeat (c) @(posedge i_core_clk);
    endtask

    task automatic waitcur(input int v);
        for (n = 0; n < 800 && o_status.current != 16'(v); n++) cyc(1);
        if (n == 800) hang();
    endtask

    initial begin
        i_core_clk = 1'b0;
        forever #25 i_core_clk = ~i_core_clk;
    end

    initial begin
        bad_count = 0;
        checks = 0;
        i_rst_n = 1'b0;
        ce = 1'b1;
        cyc(20);
        i_rst_n <= 1'b1;
        cyc(1);
        check("rst_cur", o_status.current, 1);
        check("rst_out", o_discrete, 0);
        p_u.rd(12'h300, rv, rr);
        check("unmapped", rr, RESP_SLVERR);
        p_u.wr(12'h300, 32'h1);
        check("wr_unmapped", bresp, RESP_SLVERR);
        // Target above range is capped
        p_u.wr(OFF_CFG + 12'h03C, 32'h0000_FFFF);
        p_u.rd(OFF_CFG + 12'h03C, rv, rr);
        check("tgt_cap", rv, 32'h0000_270F);
        // Patterns, masks, config; step 6 left empty
        for (int k = 0; k < 16; k++) begin
            p_u.wr(OFF_PAT + 12'(4 * k), 32'(pat(k)));
            if (k != 5) p_u.wr(OFF_CFG + 12'(4 * k), (k == 3) ? 32'h10001 : 2);
        end
        for (int i = 0; i < 32; i++) p_u.wr(OFF_MASK + 12'(4 * i), 32'(msk(i)));
        p_u.wr(OFF_MBASE, 2);
        p_u.wr(OFF_TBASE, 1);
        p_u.wr(OFF_CTRL, 32'h01);
        cyc(3);
        check("disc", o_discrete, pat(0) & msk(2));
        p_u.wr(OFF_MASK + 12'h008, 32'h00FF);
        cyc(3);
        check("mask_upd", o_discrete, pat(0) & 16'h00FF);
        p_u.wr(OFF_CTRL, 32'h11);
        cyc(3);
        check("word", o_word_out, pat(0) & 16'h00FF);
        check("word_disc", o_discrete, 0);
        p_u.wr(OFF_CTRL, 32'h19);
        p_u.wr(OFF_CTRL, 32'h11);
        cyc(3);
        check("jog_cur", o_status.current, 2);
        check("jog_out", o_word_out, pat(1) & msk(3));
        p_u.wr(OFF_PRESET, 17);
        p_u.rd(OFF_PRESET, rv, rr);
        check("pre_bad", rv, 1);
        p_u.wr(OFF_PRESET, 3);
        p_u.wr(OFF_COUNT, 5);
        p_u.wr(OFF_CTRL, 32'h15);
        p_u.wr(OFF_CTRL, 32'h11);
        cyc(20);
        check("no_start", o_status.current, 3);
        for (int i = 0; i < 4; i++) begin
            p_u.rd(OFF_COUNT + 12'(4 * i), rv, rr);
            check("status", rv, (i < 2) ? 0 : 3);
        end
        p_u.wr(OFF_CTRL, 32'h13);
        // Clock enable low freezes the running timer
        ce <= 1'b0;
        cyc(40);
        check("ce_hold", o_status.current, 3);
        ce <= 1'b1;
        waitcur(4);
        cyc(20);
        check("ev_wait", o_status.current, 4);
        p_u.wr(OFF_EVENT, 32'h8);
        waitcur(5);
        for (n = 0; n < 50 && o_status.current == 16'd5; n++) cyc(1);
        check("step_len", n, 8);
        cyc(1);
        check("skip", o_status.current, 7);
        for (n = 0; n < 800 && o_complete !== 1'b1; n++) cyc(1);
        if (n == 800) hang();
        cyc(20);
        check("done", o_complete, 1);
        check("halt", o_status.current, 16);
        check("done_out", o_word_out, pat(15) & msk(17));
        p_u.wr(OFF_CTRL, 32'h15);
        cyc(3);
        check("clr", o_complete, 0);
        check("reload", o_status.current, 3);
        conclude();
    end
endmodule
`default_nettype wire
